// ### link_recovery_pkg.sv
package link_recovery_pkg;

  // APB byte offsets
  localparam logic [7:0] OFF_EDIT       = 8'h00;
  localparam logic [7:0] OFF_COMMAND    = 8'h04;
  localparam logic [7:0] OFF_ACTIVE     = 8'h08;
  localparam logic [7:0] OFF_STATE      = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;

  // Settings word layout (edit and active registers)
  localparam int TMO_LSB    = 0;
  localparam int TMO_W      = 4;
  localparam int RETRY_LSB  = 8;
  localparam int RETRY_W    = 8;
  localparam int AUTO_BIT   = 16;
  localparam int SCANA_BIT  = 17;

  // Command register bits
  localparam int CMD_COMMIT = 0;
  localparam int CMD_CANCEL = 1;

  // State register layout
  localparam int ST_LSB     = 0;
  localparam int ST_W       = 3;
  localparam int CNT_LSB    = 8;

  // Interrupt bits
  localparam int IRQ_W         = 4;
  localparam int IRQ_TIMEOUT   = 0;
  localparam int IRQ_COMM_ERR  = 1;
  localparam int IRQ_HALTED    = 2;
  localparam int IRQ_RECOVERED = 3;

  // Factory values and limits
  localparam logic [3:0] TMO_DEFAULT   = 4'h1;
  localparam logic [3:0] TMO_MAX       = 4'hA;
  localparam logic [3:0] TMO_MIN       = 4'h0;
  localparam logic [7:0] RETRY_DEFAULT = 8'h05;
  localparam logic       AUTO_DEFAULT  = 1'b0;
  localparam logic       SCANA_DEFAULT = 1'b0;

  // Timing
  localparam int unsigned SECOND_NS     = 1000000000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_RUN   = 3'h0,
    ST_WAIT  = 3'h1,
    ST_RETRY = 3'h2,
    ST_HALT  = 3'h3
  } link_state_t;

endpackage

// ### second_timer.sv
`timescale 1ns/10ps
module second_timer #(
  parameter int unsigned SEC_CYCLES = link_recovery_pkg::SECOND_CYCLES
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       restart_i,
  output logic [3:0]      seconds_o
);

  logic [31:0] cycle_reg;
  logic [3:0]  seconds_reg;

  // Counts whole elapsed seconds, saturating at the top value
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || restart_i) begin
      cycle_reg   <= 32'h0000_0000;
      seconds_reg <= 4'h0;
    end else if (cycle_reg == SEC_CYCLES - 1) begin
      cycle_reg <= 32'h0000_0000;
      if (seconds_reg != 4'hF) begin
        seconds_reg <= seconds_reg + 4'h1;
      end
    end else begin
      cycle_reg <= cycle_reg + 32'h0000_0001;
    end
  end

  assign seconds_o = seconds_reg;

endmodule

// ### host_link_error_recovery.sv
// Functional notes
// - A request left unanswered past the response wait limit is a timeout error.
// - The wait limit is set in whole seconds from 0 to 10 and resets to 1.
// - Each selector press adds one second, wrapping from 10 to 0.
// - The attempt limit is set from 0 to 255 and resets to 5.
// - A communication error is retried up to the attempt limit before failing.
// - With auto-recover on, retries go on forever with no error indication.
// - With auto-recover off, an exhausted limit halts and raises the error indication.
// - Operator acknowledge restores the prior display and resumes reconnecting.
// - Auto-recover resets to off.
// - While halted, any two of four corners pressed together open the system menu.
// - Edits act only on commit; cancel restores the edits from the active values.
// - With port A given to a bar code reader, the host link uses port B.
// - Auto-recovery returns to normal with at most a brief initialising pulse.
`timescale 1ns/10ps
module host_link_error_recovery #(
  parameter int unsigned SEC_CYCLES = link_recovery_pkg::SECOND_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        req_start_i,
  input  wire logic        resp_i,
  input  wire logic        comm_err_i,
  input  wire logic        ack_ok_i,
  input  wire logic        wait_sel_i,
  input  wire logic [3:0]  corner_i,
  output logic             retry_o,
  output logic             error_ind_o,
  output logic             run_mode_o,
  output logic             restore_display_o,
  output logic             init_ind_o,
  output logic             menu_open_o,
  output logic             host_on_port_b_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction

  logic [31:0]                        prdata_reg;
  logic                               pready_reg;
  logic                               pslverr_reg;
  logic [3:0]                         edit_tmo_reg;
  logic [7:0]                         edit_retry_reg;
  logic                               edit_auto_reg;
  logic                               edit_scana_reg;
  logic [3:0]                         act_tmo_reg;
  logic [7:0]                         act_retry_reg;
  logic                               act_auto_reg;
  logic                               act_scana_reg;
  logic [link_recovery_pkg::IRQ_W-1:0] irq_status_reg;
  logic [link_recovery_pkg::IRQ_W-1:0] irq_enable_reg;
  logic [link_recovery_pkg::IRQ_W-1:0] irq_set;
  logic [link_recovery_pkg::IRQ_W-1:0] irq_clr;
  link_recovery_pkg::link_state_t     state_reg;
  link_recovery_pkg::link_state_t     state_next;
  logic [7:0]                         retry_cnt_reg;
  logic                               recovering_reg;
  logic                               retry_reg;
  logic                               error_ind_reg;
  logic                               run_mode_reg;
  logic                               restore_reg;
  logic                               init_ind_reg;
  logic                               menu_open_reg;
  logic                               port_b_reg;
  logic                               irq_reg;
  logic [3:0]                         seconds;
  logic                               wr_take;
  logic                               setup;
  logic                               timed_out;
  logic                               fail;
  logic                               fail_retry;
  logic                               commit;
  logic                               cancel;
  logic [2:0]                         corner_sum;
  logic [31:0]                        read_mux;
  logic                               mapped;

  assign setup   = psel_i && !penable_i;
  assign wr_take = psel_i && penable_i && pready_reg && pwrite_i;
  assign commit  = wr_take && hit(paddr_i, link_recovery_pkg::OFF_COMMAND)
                   && pwdata_i[link_recovery_pkg::CMD_COMMIT];
  assign cancel  = wr_take && hit(paddr_i, link_recovery_pkg::OFF_COMMAND)
                   && pwdata_i[link_recovery_pkg::CMD_CANCEL];

  ////////////////////////////////////////////////////////////////////////////
  // APB read path: data and ready are latched in the setup cycle
  always_comb begin
    read_mux = 32'h0000_0000;
    mapped   = 1'b1;
    if (hit(paddr_i, link_recovery_pkg::OFF_EDIT)) begin
      read_mux[link_recovery_pkg::TMO_LSB +: link_recovery_pkg::TMO_W]     = edit_tmo_reg;
      read_mux[link_recovery_pkg::RETRY_LSB +: link_recovery_pkg::RETRY_W] = edit_retry_reg;
      read_mux[link_recovery_pkg::AUTO_BIT]  = edit_auto_reg;
      read_mux[link_recovery_pkg::SCANA_BIT] = edit_scana_reg;
    end else if (hit(paddr_i, link_recovery_pkg::OFF_ACTIVE)) begin
      read_mux[link_recovery_pkg::TMO_LSB +: link_recovery_pkg::TMO_W]     = act_tmo_reg;
      read_mux[link_recovery_pkg::RETRY_LSB +: link_recovery_pkg::RETRY_W] = act_retry_reg;
      read_mux[link_recovery_pkg::AUTO_BIT]  = act_auto_reg;
      read_mux[link_recovery_pkg::SCANA_BIT] = act_scana_reg;
    end else if (hit(paddr_i, link_recovery_pkg::OFF_STATE)) begin
      read_mux[link_recovery_pkg::ST_LSB +: link_recovery_pkg::ST_W] = state_reg;
      read_mux[link_recovery_pkg::CNT_LSB +: link_recovery_pkg::RETRY_W] = retry_cnt_reg;
    end else if (hit(paddr_i, link_recovery_pkg::OFF_IRQ_STATUS)) begin
      read_mux[link_recovery_pkg::IRQ_W-1:0] = irq_status_reg;
    end else if (hit(paddr_i, link_recovery_pkg::OFF_IRQ_ENABLE)) begin
      read_mux[link_recovery_pkg::IRQ_W-1:0] = irq_enable_reg;
    end else if (!hit(paddr_i, link_recovery_pkg::OFF_COMMAND)
                 && !hit(paddr_i, link_recovery_pkg::OFF_IRQ_CLEAR)) begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup && !pwrite_i) begin
        prdata_reg <= read_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edit copy of the settings
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      edit_tmo_reg   <= link_recovery_pkg::TMO_DEFAULT;
      edit_retry_reg <= link_recovery_pkg::RETRY_DEFAULT;
      edit_auto_reg  <= link_recovery_pkg::AUTO_DEFAULT;
      edit_scana_reg <= link_recovery_pkg::SCANA_DEFAULT;
    end else if (cancel) begin
      edit_tmo_reg   <= act_tmo_reg;
      edit_retry_reg <= act_retry_reg;
      edit_auto_reg  <= act_auto_reg;
      edit_scana_reg <= act_scana_reg;
    end else if (wr_take && hit(paddr_i, link_recovery_pkg::OFF_EDIT)) begin
      // Out-of-range wait limits are held at the top of the range
      if (pwdata_i[link_recovery_pkg::TMO_LSB +: link_recovery_pkg::TMO_W]
          > link_recovery_pkg::TMO_MAX) begin
        edit_tmo_reg <= link_recovery_pkg::TMO_MAX;
      end else begin
        edit_tmo_reg <= pwdata_i[link_recovery_pkg::TMO_LSB +: link_recovery_pkg::TMO_W];
      end
      edit_retry_reg <= pwdata_i[link_recovery_pkg::RETRY_LSB +: link_recovery_pkg::RETRY_W];
      edit_auto_reg  <= pwdata_i[link_recovery_pkg::AUTO_BIT];
      edit_scana_reg <= pwdata_i[link_recovery_pkg::SCANA_BIT];
    end else if (wait_sel_i) begin
      if (edit_tmo_reg >= link_recovery_pkg::TMO_MAX) begin
        edit_tmo_reg <= link_recovery_pkg::TMO_MIN;
      end else begin
        edit_tmo_reg <= edit_tmo_reg + 4'h1;
      end
    end
  end

  // Active settings change only on commit
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      act_tmo_reg   <= link_recovery_pkg::TMO_DEFAULT;
      act_retry_reg <= link_recovery_pkg::RETRY_DEFAULT;
      act_auto_reg  <= link_recovery_pkg::AUTO_DEFAULT;
      act_scana_reg <= link_recovery_pkg::SCANA_DEFAULT;
    end else if (commit && !cancel) begin
      act_tmo_reg   <= edit_tmo_reg;
      act_retry_reg <= edit_retry_reg;
      act_auto_reg  <= edit_auto_reg;
      act_scana_reg <= edit_scana_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link recovery sequencer
  second_timer #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_timer (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (state_reg != link_recovery_pkg::ST_WAIT),
    .seconds_o (seconds)
  );

  assign timed_out  = (state_reg == link_recovery_pkg::ST_WAIT) && (seconds >= act_tmo_reg);
  assign fail       = !resp_i && (timed_out || (comm_err_i &&
                      ((state_reg == link_recovery_pkg::ST_WAIT) ||
                       (state_reg == link_recovery_pkg::ST_RUN))));
  assign fail_retry = act_auto_reg || (retry_cnt_reg < act_retry_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      link_recovery_pkg::ST_RUN: begin
        if (fail) begin
          state_next = fail_retry ? link_recovery_pkg::ST_RETRY : link_recovery_pkg::ST_HALT;
        end else if (req_start_i) begin
          state_next = link_recovery_pkg::ST_WAIT;
        end
      end
      link_recovery_pkg::ST_WAIT: begin
        if (resp_i) begin
          state_next = link_recovery_pkg::ST_RUN;
        end else if (fail) begin
          state_next = fail_retry ? link_recovery_pkg::ST_RETRY : link_recovery_pkg::ST_HALT;
        end
      end
      link_recovery_pkg::ST_RETRY: begin
        state_next = link_recovery_pkg::ST_WAIT;
      end
      link_recovery_pkg::ST_HALT: begin
        if (ack_ok_i) begin
          state_next = link_recovery_pkg::ST_RETRY;
        end
      end
      default: begin
        state_next = link_recovery_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= link_recovery_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Attempt count and recovery flag
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      retry_cnt_reg  <= 8'h00;
      recovering_reg <= 1'b0;
    end else if ((state_reg == link_recovery_pkg::ST_WAIT) && resp_i) begin
      retry_cnt_reg  <= 8'h00;
      recovering_reg <= 1'b0;
    end else if ((state_reg == link_recovery_pkg::ST_HALT) && ack_ok_i) begin
      retry_cnt_reg  <= 8'h00;
    end else if (fail) begin
      recovering_reg <= 1'b1;
      if (!act_auto_reg && fail_retry) begin
        retry_cnt_reg <= retry_cnt_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_comb begin
    corner_sum = 3'h0;
    for (int i = 0; i < 4; i++) begin
      corner_sum = corner_sum + {2'h0, corner_i[i]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      retry_reg     <= 1'b0;
      error_ind_reg <= 1'b0;
      run_mode_reg  <= 1'b1;
      restore_reg   <= 1'b0;
      init_ind_reg  <= 1'b0;
      menu_open_reg <= 1'b0;
      port_b_reg    <= 1'b0;
    end else begin
      retry_reg     <= (state_next == link_recovery_pkg::ST_RETRY);
      error_ind_reg <= (state_next == link_recovery_pkg::ST_HALT);
      run_mode_reg  <= (state_next != link_recovery_pkg::ST_HALT);
      restore_reg   <= (state_reg == link_recovery_pkg::ST_HALT) && ack_ok_i;
      init_ind_reg  <= fail && act_auto_reg;
      menu_open_reg <= (state_reg == link_recovery_pkg::ST_HALT)
                       && (corner_sum >= 3'h2);
      port_b_reg    <= act_scana_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over clear
  always_comb begin
    irq_set = '0;
    irq_set[link_recovery_pkg::IRQ_TIMEOUT]   = timed_out && !resp_i;
    irq_set[link_recovery_pkg::IRQ_COMM_ERR]  = fail && comm_err_i;
    irq_set[link_recovery_pkg::IRQ_HALTED]    = (state_next == link_recovery_pkg::ST_HALT)
                                                && (state_reg != link_recovery_pkg::ST_HALT);
    irq_set[link_recovery_pkg::IRQ_RECOVERED] = (state_reg == link_recovery_pkg::ST_WAIT)
                                                && resp_i && recovering_reg;
    irq_clr = '0;
    if (wr_take && hit(paddr_i, link_recovery_pkg::OFF_IRQ_CLEAR)) begin
      irq_clr = pwdata_i[link_recovery_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_status_reg <= '0;
      irq_enable_reg <= '0;
      irq_reg        <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      if (wr_take && hit(paddr_i, link_recovery_pkg::OFF_IRQ_ENABLE)) begin
        irq_enable_reg <= pwdata_i[link_recovery_pkg::IRQ_W-1:0];
      end
      irq_reg <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_enable_reg);
    end
  end

  assign prdata_o          = prdata_reg;
  assign pready_o          = pready_reg;
  assign pslverr_o         = pslverr_reg;
  assign retry_o           = retry_reg;
  assign error_ind_o       = error_ind_reg;
  assign run_mode_o        = run_mode_reg;
  assign restore_display_o = restore_reg;
  assign init_ind_o        = init_ind_reg;
  assign menu_open_o       = menu_open_reg;
  assign host_on_port_b_o  = port_b_reg;
  assign irq_o             = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence seq_retry_then_wait;
    (state_reg == link_recovery_pkg::ST_RETRY) && retry_o ##1
    (state_reg == link_recovery_pkg::ST_WAIT);
  endsequence

  sequence seq_halted;
    (state_reg == link_recovery_pkg::ST_HALT) && error_ind_o && !run_mode_o;
  endsequence

  chk_timeout_flag: assert property (
    (state_reg == link_recovery_pkg::ST_WAIT) && (seconds >= act_tmo_reg) && !resp_i
    |=> irq_status_reg[link_recovery_pkg::IRQ_TIMEOUT] && (state_reg != link_recovery_pkg::ST_WAIT))
    else $error("timeout not flagged");

  chk_selector_wrap: assert property (
    wait_sel_i && !wr_take && (edit_tmo_reg == link_recovery_pkg::TMO_MAX)
    |=> (edit_tmo_reg == link_recovery_pkg::TMO_MIN))
    else $error("wait limit did not wrap");

  chk_counted_retry: assert property (
    fail && !act_auto_reg && (retry_cnt_reg < act_retry_reg)
    |=> seq_retry_then_wait)
    else $error("counted retry missing");

  chk_auto_retry: assert property (
    fail && act_auto_reg |=> seq_retry_then_wait and (!error_ind_o && run_mode_o && init_ind_o))
    else $error("auto recovery misbehaved");

  chk_halt_exhaust: assert property (
    fail && !act_auto_reg && (retry_cnt_reg >= act_retry_reg) |=> seq_halted)
    else $error("exhausted limit did not halt");

  chk_ack_resume: assert property (
    (state_reg == link_recovery_pkg::ST_HALT) && ack_ok_i
    |=> restore_display_o && (retry_cnt_reg == 8'h00) ##0 seq_retry_then_wait)
    else $error("acknowledge did not resume");

  chk_corner_menu: assert property (
    menu_open_o |-> ($past(state_reg) == link_recovery_pkg::ST_HALT) && ($countones($past(corner_i)) >= 2))
    else $error("menu opened wrongly");

  chk_commit_only: assert property (
    !$past(commit) |-> $stable(act_tmo_reg) && $stable(act_retry_reg) && $stable(act_auto_reg))
    else $error("active settings changed without commit");

endmodule

// ### host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ask_i,
  input  wire logic       answer_en_i,
  input  wire logic [7:0] delay_i,
  output logic            resp_o
);
  logic [7:0] cnt_reg;
  logic       busy_reg;

  // Silent host never answers; otherwise one reply delay_i+2 cycles after the request
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_reg  <= 8'h00;
      busy_reg <= 1'b0;
      resp_o   <= 1'b0;
    end else begin
      resp_o <= 1'b0;
      if (ask_i && answer_en_i) begin
        busy_reg <= 1'b1;
        cnt_reg  <= delay_i;
      end else if (busy_reg) begin
        if (cnt_reg == 8'h00) begin
          resp_o   <= 1'b1;
          busy_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      end
    end
  end
endmodule

// ### tb_host_link_error_recovery.sv
`timescale 1ns/10ps
module tb_host_link_error_recovery;
  logic clock_i, sys_rst_i, psel_i, penable_i, pwrite_i, req_start_i, resp_i, comm_err_i;
  logic ack_ok_i, wait_sel_i, pready_o, pslverr_o, retry_o, error_ind_o, run_mode_o;
  logic restore_display_o, init_ind_o, menu_open_o, host_on_port_b_o, irq_o;
  logic answer_en, err_seen, rest_seen;
  logic [7:0] paddr_i, delay;
  logic [3:0] corner_i;
  logic [31:0] pwdata_i, prdata_o, rdata;
  logic rerr;
  int miscompares, n_tests, nret, ninit, cyc;

  host_link_error_recovery #(.SEC_CYCLES(20)) dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .req_start_i(req_start_i), .resp_i(resp_i),
    .comm_err_i(comm_err_i), .ack_ok_i(ack_ok_i), .wait_sel_i(wait_sel_i),
    .corner_i(corner_i), .retry_o(retry_o), .error_ind_o(error_ind_o),
    .run_mode_o(run_mode_o), .restore_display_o(restore_display_o),
    .init_ind_o(init_ind_o), .menu_open_o(menu_open_o),
    .host_on_port_b_o(host_on_port_b_o), .irq_o(irq_o));

  host_model host (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ask_i(req_start_i | retry_o),
    .answer_en_i(answer_en), .delay_i(delay), .resp_o(resp_i));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (retry_o === 1'b1) nret++;
    if (init_ind_o === 1'b1) ninit++;
    if (error_ind_o === 1'b1) err_seen = 1'b1;
    if (restore_display_o === 1'b1) rest_seen = 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      $display("mismatch %0t run did not finish", $time);
      print_verdict();
    end
  end

  function automatic logic [31:0] cfg(input logic [3:0] t, input logic [7:0] r,
                                      input logic a, input logic s);
    return {14'h0, s, a, r, 4'h0, t};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) @(posedge clock_i);
    rdata = prdata_o;
    rerr  = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic commit(input logic [31:0] v);
    apb(1'b1, link_recovery_pkg::OFF_EDIT, v);
    apb(1'b1, link_recovery_pkg::OFF_COMMAND, 32'h0000_0001);
  endtask

  task automatic request();
    @(posedge clock_i) req_start_i <= 1'b1;
    @(posedge clock_i) req_start_i <= 1'b0;
  endtask

  task automatic wait_halt();
    for (int i = 0; i < 600 && error_ind_o !== 1'b1; i++) @(posedge clock_i);
  endtask

  task automatic wait_run();
    for (int i = 0; i < 600 && run_mode_o !== 1'b1; i++) @(posedge clock_i);
    tick(30);
    apb(1'b0, link_recovery_pkg::OFF_STATE, 32'h0);
  endtask

  task automatic test_reset_values();
    apb(1'b0, link_recovery_pkg::OFF_ACTIVE, 32'h0);
    chk(rdata, cfg(4'h1, 8'h05, 1'b0, 1'b0), "factory settings");
    chk({31'h0, run_mode_o}, 32'h1, "run after reset");
    apb(1'b0, 8'h3C, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    $display("test reset values done");
  endtask

  task automatic test_selector_and_commit();
    for (int i = 1; i <= 10; i++) begin
      @(posedge clock_i) wait_sel_i <= 1'b1;
      @(posedge clock_i) wait_sel_i <= 1'b0;
      apb(1'b0, link_recovery_pkg::OFF_EDIT, 32'h0);
      chk(rdata & 32'hF, (i == 10) ? 32'h0 : 32'(i + 1), "selector step");
    end
    apb(1'b1, link_recovery_pkg::OFF_EDIT, cfg(4'h3, 8'h07, 1'b0, 1'b1));
    apb(1'b1, link_recovery_pkg::OFF_COMMAND, 32'h0000_0002);
    apb(1'b0, link_recovery_pkg::OFF_ACTIVE, 32'h0);
    chk(rdata, cfg(4'h1, 8'h05, 1'b0, 1'b0), "cancel keeps active");
    apb(1'b0, link_recovery_pkg::OFF_EDIT, 32'h0);
    chk(rdata, cfg(4'h1, 8'h05, 1'b0, 1'b0), "cancel drops edits");
    chk({31'h0, host_on_port_b_o}, 32'h0, "port b before commit");
    commit(cfg(4'h3, 8'h07, 1'b0, 1'b1));
    apb(1'b0, link_recovery_pkg::OFF_ACTIVE, 32'h0);
    chk(rdata, cfg(4'h3, 8'h07, 1'b0, 1'b1), "commit applies");
    chk({31'h0, host_on_port_b_o}, 32'h1, "host on port b");
    $display("test selector and commit done");
  endtask

  task automatic test_halt_and_ack();
    commit(cfg(4'h1, 8'h02, 1'b0, 1'b0));
    apb(1'b1, link_recovery_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
    nret = 0;
    request();
    wait_halt();
    chk({31'h0, error_ind_o}, 32'h1, "halt after timeouts");
    chk(32'(nret), 32'h2, "retries before halt");
    chk({31'h0, run_mode_o}, 32'h0, "run left");
    chk({31'h0, irq_o}, 32'h1, "timeout irq");
    corner_i <= 4'h1;
    tick(3);
    chk({31'h0, menu_open_o}, 32'h0, "one corner");
    corner_i <= 4'h9;
    tick(3);
    chk({31'h0, menu_open_o}, 32'h1, "two corners");
    corner_i <= 4'h0;
    answer_en <= 1'b1;
    rest_seen = 1'b0;
    @(posedge clock_i) ack_ok_i <= 1'b1;
    @(posedge clock_i) ack_ok_i <= 1'b0;
    tick(2);
    chk({31'h0, rest_seen}, 32'h1, "display restored");
    wait_run();
    chk(rdata & 32'h7, 32'h0, "link resumed");
    apb(1'b0, link_recovery_pkg::OFF_IRQ_STATUS, 32'h0);
    chk(rdata & 32'h5, 32'h5, "timeout and halt status");
    apb(1'b1, link_recovery_pkg::OFF_IRQ_CLEAR, 32'h0000_000F);
    tick(2);
    chk({31'h0, irq_o}, 32'h0, "irq cleared");
    $display("test halt and ack done");
  endtask

  task automatic test_auto_recover();
    commit(cfg(4'h1, 8'h02, 1'b1, 1'b0));
    answer_en <= 1'b0;
    nret = 0;
    ninit = 0;
    err_seen = 1'b0;
    request();
    tick(200);
    chk({31'h0, err_seen}, 32'h0, "no error screen");
    chk({31'h0, run_mode_o}, 32'h1, "stays in run");
    chk(32'(nret > 4), 32'h1, "retries beyond limit");
    chk(32'(ninit > 0), 32'h1, "initialising shown");
    answer_en <= 1'b1;
    tick(60);
    apb(1'b0, link_recovery_pkg::OFF_STATE, 32'h0);
    chk(rdata & 32'h7, 32'h0, "recovered to run");
    @(posedge clock_i) comm_err_i <= 1'b1;
    @(posedge clock_i) comm_err_i <= 1'b0;
    tick(20);
    apb(1'b0, link_recovery_pkg::OFF_IRQ_STATUS, 32'h0);
    chk(rdata & 32'hA, 32'hA, "comm error retried and recovered");
    chk({31'h0, run_mode_o}, 32'h1, "run after comm error");
    $display("test auto recover done");
  endtask

  task automatic test_zero_limit();
    commit(cfg(4'hF, 8'h00, 1'b0, 1'b0));
    apb(1'b0, link_recovery_pkg::OFF_ACTIVE, 32'h0);
    chk(rdata, cfg(4'hA, 8'h00, 1'b0, 1'b0), "wait limit clamped");
    answer_en <= 1'b0;
    nret = 0;
    request();
    @(posedge clock_i) comm_err_i <= 1'b1;
    @(posedge clock_i) comm_err_i <= 1'b0;
    tick(3);
    chk({31'h0, error_ind_o}, 32'h1, "halt at first error");
    chk(32'(nret), 32'h0, "no retry");
    $display("test zero limit done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {psel_i, penable_i, pwrite_i, req_start_i, comm_err_i, ack_ok_i, wait_sel_i} = '0;
    {paddr_i, pwdata_i, corner_i, answer_en, err_seen, rest_seen} = '0;
    delay = 8'h04;
    sys_rst_i = 1'b1;
    tick(5);
    sys_rst_i <= 1'b0;
    test_reset_values();
    test_selector_and_commit();
    test_halt_and_ack();
    test_auto_recover();
    test_zero_limit();
    print_verdict();
  end
endmodule
